// ==== hw/tls_pkg.sv ====
// Package: register map, fields, reset values and timing for the supervisor
package tls_pkg;
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned TICK_SEC_CYC  = CLK_HZ;
  localparam int unsigned SEC_PER_MIN   = 60;
  localparam int          ADDR_W        = 4;
  localparam int          DATA_W        = 32;
  localparam int          SW_W          = 16;

  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_BYPASS = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_SHDN   = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_ALMSW  = 4'hC;
  // Second bank selected by address bit 3 overlap avoided: wider map below
  localparam int          MAP_W         = 6;
  localparam logic [MAP_W-1:0] R_CTRL    = 6'h00;
  localparam logic [MAP_W-1:0] R_BYPASS  = 6'h04;
  localparam logic [MAP_W-1:0] R_SHDN    = 6'h08;
  localparam logic [MAP_W-1:0] R_HOLD    = 6'h0C;
  localparam logic [MAP_W-1:0] R_RESTART = 6'h10;
  localparam logic [MAP_W-1:0] R_ALMSW   = 6'h14;
  localparam logic [MAP_W-1:0] R_STATUS  = 6'h18;
  localparam logic [MAP_W-1:0] R_IRQ_ST  = 6'h1C;
  localparam logic [MAP_W-1:0] R_IRQ_CLR = 6'h20;
  localparam logic [MAP_W-1:0] R_IRQ_EN  = 6'h24;
  localparam logic [MAP_W-1:0] R_CMD     = 6'h28;

  // CTRL fields
  localparam int CTRL_LOCKOUT_EN = 0;
  localparam int CTRL_LOCAL_RST  = 1;
  // CMD fields (write-only pulses)
  localparam int CMD_MAN_START   = 0;
  localparam int CMD_LOCK_CLR    = 1;
  // Alarm switch bit positions
  localparam int SW_UNDERLOAD  = 0;
  localparam int SW_HEAVY_LOAD = 1;
  localparam int SW_SLOW_SPEED = 2;
  localparam int SW_AUX_TEMP   = 3;
  localparam int SW_HIGH_VOLT  = 4;
  localparam int SW_LOW_VOLT   = 5;
  localparam int SW_UNBALANCE  = 6;
  localparam int SW_DIN1       = 7;
  localparam int SW_DIN2       = 8;
  localparam int SW_DIN3       = 9;
  localparam int SW_AIN1_HI    = 10;
  localparam int SW_AIN1_LO    = 11;
  localparam int SW_AIN2_HI    = 12;
  localparam int SW_AIN2_LO    = 13;
  localparam int SW_COMM_LOSS  = 14;
  localparam int SW_BAD_CLOCK  = 15;
  // RESTART fields
  localparam int RST_STARTS_LSB = 0;
  localparam int RST_STARTS_W   = 8;
  localparam int RST_DELAY_LSB  = 8;
  localparam int RST_DELAY_W    = 16;
  // STATUS / IRQ bits
  localparam int ST_LOSS     = 0;
  localparam int ST_RUN      = 1;
  localparam int ST_LOCKED   = 2;
  localparam int ST_BYPASS   = 3;
  localparam int ST_START_OK = 4;
  localparam int IRQ_W       = 4;
  localparam int IRQ_TRIP    = 0;
  localparam int IRQ_LOCK    = 1;
  localparam int IRQ_RESTART = 2;
  localparam int IRQ_LOSS    = 3;

  // Reset values
  localparam logic [15:0] RST_BYPASS_SEC  = 16'h0002;
  localparam logic [15:0] RST_SHDN_SEC    = 16'h0258;
  localparam logic [15:0] RST_HOLD_SEC    = 16'h001E;
  localparam logic [7:0]  RST_STARTS      = 8'h03;
  localparam logic [15:0] RST_DELAY_MIN   = 16'h001E;
  localparam logic [SW_W-1:0] RST_ALMSW   = 16'h0007;

  typedef enum logic [1:0] {
    TLS_IDLE,
    TLS_RUN,
    TLS_WAIT,
    TLS_LOCK
  } tls_state_t;
endpackage

// ==== hw/tls_tick_div.sv ====
// Divider: one-cycle second tick and minute tick enables
`timescale 1ns/1ps
module tls_tick_div #(
  parameter int unsigned SEC_CYC = tls_pkg::TICK_SEC_CYC
) (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic arst_n_i,
  // Ticks
  output logic      sec_tick_o,
  output logic      min_tick_o
);
  import tls_pkg::*;

  typedef struct packed {
    logic [31:0] cyc;
    logic [5:0]  sec;
    logic        st;
    logic        mt;
  } tls_div_t;

  tls_div_t s_reg;
  tls_div_t s_next;

  always_comb
  begin
    s_next    = s_reg;
    s_next.st = 1'b0;
    s_next.mt = 1'b0;
    if (s_reg.cyc == 32'(SEC_CYC - 1))
    begin
      s_next.cyc = 32'h0;
      s_next.st  = 1'b1;
      if (s_reg.sec == 6'(SEC_PER_MIN - 1))
      begin
        s_next.sec = 6'h0;
        s_next.mt  = 1'b1;
      end
      else
        s_next.sec = s_reg.sec + 6'h1;
    end
    else
      s_next.cyc = s_reg.cyc + 32'h1;
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign sec_tick_o = s_reg.st;
  assign min_tick_o = s_reg.mt;
endmodule

// ==== hw/tls_sync.sv ====
// Two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module tls_sync #(
  parameter int W = 3
) (
  // Clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         arst_n_i,
  // Levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] f1;
    logic [W-1:0] f2;
  } tls_sync_t;

  tls_sync_t s_reg;
  tls_sync_t s_next;

  always_comb
  begin
    s_next    = s_reg;
    s_next.f1 = async_i;
    s_next.f2 = s_reg.f1;
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign sync_o = s_reg.f2;
endmodule

// ==== hw/tls_supervisor.sv ====
// Telemetry loss supervisor: timers, start permission, restart policy
//
// Behaviour
// - Loss flagged unless own exchange in progress
// - Stop only if enabled and timers expired
// - Lockout on loss trip refuses all starts
// - Ignore loss for bypass seconds after start
// - Loss must persist shutdown seconds to stop
// - Shutdown timing starts after bypass expires
// - Start under loss needs recent link traffic
// - Hold-off re-armed by any traffic
// - Local or global restart settings by selector
// - Local restarts limited to allowed count
// - Local restart waits programmed delay minutes
// - Consolidated alarm switches equal own enables
`timescale 1ns/1ps
module tls_supervisor #(
  parameter int unsigned SEC_CYC = tls_pkg::TICK_SEC_CYC
) (
  // Clock and reset
  input  wire logic                       ref_clk_i,
  input  wire logic                       arst_n_i,
  // Register port
  input  wire logic [tls_pkg::MAP_W-1:0]  addr_i,
  input  wire logic [tls_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                       wr_i,
  input  wire logic                       rd_i,
  output logic      [tls_pkg::DATA_W-1:0] rdata_o,
  // Link activity pins
  input  wire logic                       own_rx_i,
  input  wire logic                       own_tx_i,
  input  wire logic                       any_rx_i,
  // Global restart policy
  input  wire logic [7:0]                 glb_starts_i,
  input  wire logic [15:0]                glb_delay_min_i,
  // Motor control
  input  wire logic                       start_req_i,
  output logic                            motor_run_o,
  output logic                            loss_o,
  output logic                            locked_o,
  output logic                            irq_o
);
  import tls_pkg::*;

  typedef struct packed {
    tls_state_t           st;
    logic                 lock_en;
    logic                 local_rst;
    logic [15:0]          byp_sec;
    logic [15:0]          shdn_sec;
    logic [15:0]          hold_sec;
    logic [7:0]           starts;
    logic [15:0]          dly_min;
    logic [SW_W-1:0]      almsw;
    logic [15:0]          byp_cnt;
    logic [15:0]          shdn_cnt;
    logic [15:0]          hold_cnt;
    logic [15:0]          wait_cnt;
    logic [7:0]           rst_used;
    logic                 loss_q;
    logic [IRQ_W-1:0]     irq_st;
    logic [IRQ_W-1:0]     irq_en;
    logic [DATA_W-1:0]    rdata;
  } tls_sup_t;

  tls_sup_t s_reg;
  tls_sup_t s_next;

  logic       sec_tick;
  logic       min_tick;
  logic [2:0] pins_s;
  logic       own_act;
  logic       any_act;
  logic       start_s;
  logic       loss;
  logic       in_bypass;
  logic       start_ok;
  logic [7:0] lim_starts;
  logic [15:0] lim_delay;
  logic [IRQ_W-1:0] ev;
  logic       wr_cmd;

  tls_tick_div #(
    .SEC_CYC   (SEC_CYC)
  ) u_div (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .sec_tick_o(sec_tick),
    .min_tick_o(min_tick)
  );

  tls_sync #(
    .W        (3)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .arst_n_i (arst_n_i),
    .async_i  ({any_rx_i, own_tx_i, own_rx_i}),
    .sync_o   (pins_s)
  );

  function automatic logic hit(input logic [MAP_W-1:0] a,
                               input logic [MAP_W-1:0] r);
    return a == r;
  endfunction

  // Own exchange clears loss; no exchange means loss
  assign own_act  = pins_s[0] | pins_s[1];
  assign any_act  = pins_s[2] | own_act;
  assign loss     = ~own_act;
  assign start_s  = start_req_i;
  assign in_bypass = s_reg.byp_cnt != 16'h0;
  // Traffic in the hold-off window permits a start under loss
  assign start_ok = ~s_reg.loss_q | (s_reg.hold_cnt != 16'h0);
  // Selector picks local or global restart settings
  assign lim_starts = s_reg.local_rst ? s_reg.starts : glb_starts_i;
  assign lim_delay  = s_reg.local_rst ? s_reg.dly_min : glb_delay_min_i;
  assign wr_cmd     = wr_i && hit(addr_i, R_CMD);

  always_comb
  begin
    s_next        = s_reg;
    ev            = '0;
    s_next.loss_q = loss;
    if (loss && !s_reg.loss_q)
      ev[IRQ_LOSS] = 1'b1;

    // Hold-off window re-armed by any traffic, counts down in seconds
    if (any_act)
      s_next.hold_cnt = s_reg.hold_sec;
    else if (sec_tick && s_reg.hold_cnt != 16'h0)
      s_next.hold_cnt = s_reg.hold_cnt - 16'h1;

    case (s_reg.st)
      TLS_IDLE:
      begin
        if (start_s && start_ok)
        begin
          s_next.st       = TLS_RUN;
          s_next.byp_cnt  = s_reg.byp_sec;
          s_next.shdn_cnt = s_reg.shdn_sec;
          s_next.rst_used = 8'h0;
        end
      end
      TLS_RUN:
      begin
        if (in_bypass)
        begin
          // Loss does not advance toward shutdown here
          if (sec_tick)
            s_next.byp_cnt = s_reg.byp_cnt - 16'h1;
          s_next.shdn_cnt = s_reg.shdn_sec;
        end
        else if (!loss)
          s_next.shdn_cnt = s_reg.shdn_sec;
        else if (s_reg.almsw[SW_COMM_LOSS])
        begin
          if (s_reg.shdn_cnt == 16'h0)
          begin
            ev[IRQ_TRIP] = 1'b1;
            if (s_reg.lock_en)
            begin
              s_next.st      = TLS_LOCK;
              ev[IRQ_LOCK]   = 1'b1;
            end
            else
            begin
              s_next.st       = TLS_WAIT;
              s_next.wait_cnt = lim_delay;
            end
          end
          else if (sec_tick)
            s_next.shdn_cnt = s_reg.shdn_cnt - 16'h1;
        end
      end
      TLS_WAIT:
      begin
        if (start_s && start_ok)
        begin
          s_next.st       = TLS_RUN;
          s_next.byp_cnt  = s_reg.byp_sec;
          s_next.shdn_cnt = s_reg.shdn_sec;
          s_next.rst_used = 8'h0;
        end
        else if (s_reg.wait_cnt != 16'h0)
        begin
          if (min_tick)
            s_next.wait_cnt = s_reg.wait_cnt - 16'h1;
        end
        else if (s_reg.rst_used < lim_starts && start_ok)
        begin
          s_next.st       = TLS_RUN;
          s_next.byp_cnt  = s_reg.byp_sec;
          s_next.shdn_cnt = s_reg.shdn_sec;
          s_next.rst_used = s_reg.rst_used + 8'h1;
          ev[IRQ_RESTART] = 1'b1;
        end
      end
      TLS_LOCK:
      begin
        // Every start refused until software clears lockout
        if (wr_cmd && wdata_i[CMD_LOCK_CLR])
        begin
          s_next.st       = TLS_IDLE;
          s_next.rst_used = 8'h0;
        end
      end
      default:
        s_next.st = TLS_IDLE;
    endcase

    // Software stop of a manual run is not provided; host owns start only
    if (wr_cmd && wdata_i[CMD_MAN_START] && s_reg.st == TLS_IDLE && start_ok)
    begin
      s_next.st       = TLS_RUN;
      s_next.byp_cnt  = s_reg.byp_sec;
      s_next.shdn_cnt = s_reg.shdn_sec;
      s_next.rst_used = 8'h0;
    end

    if (wr_i)
    begin
      if (hit(addr_i, R_CTRL))
      begin
        s_next.lock_en   = wdata_i[CTRL_LOCKOUT_EN];
        s_next.local_rst = wdata_i[CTRL_LOCAL_RST];
      end
      if (hit(addr_i, R_BYPASS))
        s_next.byp_sec = wdata_i[15:0];
      if (hit(addr_i, R_SHDN))
        s_next.shdn_sec = wdata_i[15:0];
      if (hit(addr_i, R_HOLD))
        s_next.hold_sec = wdata_i[15:0];
      if (hit(addr_i, R_RESTART))
      begin
        s_next.starts  = wdata_i[RST_STARTS_LSB +: RST_STARTS_W];
        s_next.dly_min = wdata_i[RST_DELAY_LSB +: RST_DELAY_W];
      end
      // Same flop as the alarm's own enable, so both views agree
      if (hit(addr_i, R_ALMSW))
        s_next.almsw = wdata_i[SW_W-1:0];
      if (hit(addr_i, R_IRQ_EN))
        s_next.irq_en = wdata_i[IRQ_W-1:0];
      if (hit(addr_i, R_IRQ_CLR))
        s_next.irq_st = s_reg.irq_st & ~wdata_i[IRQ_W-1:0];
    end
    // Set wins over a clear in the same cycle
    s_next.irq_st = s_next.irq_st | ev;

    s_next.rdata = '0;
    if (rd_i)
    begin
      case (addr_i)
        R_CTRL:    s_next.rdata = {30'h0, s_reg.local_rst, s_reg.lock_en};
        R_BYPASS:  s_next.rdata = {16'h0, s_reg.byp_sec};
        R_SHDN:    s_next.rdata = {16'h0, s_reg.shdn_sec};
        R_HOLD:    s_next.rdata = {16'h0, s_reg.hold_sec};
        R_RESTART: s_next.rdata = {8'h0, s_reg.dly_min, s_reg.starts};
        R_ALMSW:   s_next.rdata = {16'h0, s_reg.almsw};
        R_STATUS:  s_next.rdata = {27'h0, start_ok, in_bypass,
                                   s_reg.st == TLS_LOCK,
                                   s_reg.st == TLS_RUN, s_reg.loss_q};
        R_IRQ_ST:  s_next.rdata = {28'h0, s_reg.irq_st};
        R_IRQ_EN:  s_next.rdata = {28'h0, s_reg.irq_en};
        default:   s_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s_reg          <= '0;
      s_reg.st       <= TLS_IDLE;
      s_reg.loss_q   <= 1'b1;
      s_reg.byp_sec  <= RST_BYPASS_SEC;
      s_reg.shdn_sec <= RST_SHDN_SEC;
      s_reg.hold_sec <= RST_HOLD_SEC;
      s_reg.starts   <= RST_STARTS;
      s_reg.dly_min  <= RST_DELAY_MIN;
      s_reg.almsw    <= RST_ALMSW;
    end
    else
      s_reg <= s_next;
  end

  assign rdata_o     = s_reg.rdata;
  assign motor_run_o = s_reg.st == TLS_RUN;
  assign loss_o      = s_reg.loss_q;
  assign locked_o    = s_reg.st == TLS_LOCK;
  assign irq_o       = |(s_reg.irq_st & s_reg.irq_en);
endmodule

// ==== verif/tls_supervisor_sva.sv ====
// Checker: port-level properties of the loss supervisor
`timescale 1ns/1ps
module tls_supervisor_sva (
  // Clock and reset
  input wire logic                       ref_clk_i,
  input wire logic                       arst_n_i,
  // Register port
  input wire logic [tls_pkg::MAP_W-1:0]  addr_i,
  input wire logic [tls_pkg::DATA_W-1:0] wdata_i,
  input wire logic                       wr_i,
  input wire logic                       rd_i,
  input wire logic [tls_pkg::DATA_W-1:0] rdata_o,
  // Link and motor
  input wire logic                       own_rx_i,
  input wire logic                       own_tx_i,
  input wire logic                       motor_run_o,
  input wire logic                       loss_o,
  input wire logic                       locked_o
);
  import tls_pkg::*;
  logic sw_reg;
  logic lk_reg;
  logic unlock;
  assign unlock = wr_i && addr_i == R_CMD && wdata_i[CMD_LOCK_CLR];
  // Shadow of the enables that decide trip and lockout
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      sw_reg <= RST_ALMSW[SW_COMM_LOSS];
      lk_reg <= 1'b0;
    end
    else if (wr_i && addr_i == R_ALMSW)
      sw_reg <= wdata_i[SW_COMM_LOSS];
    else if (wr_i && addr_i == R_CTRL)
      lk_reg <= wdata_i[CTRL_LOCKOUT_EN];
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  // Five samples cover the pin sync and the status flop
  sequence s_quiet;
    !(own_rx_i || own_tx_i) [*5];
  endsequence
  sequence s_talk;
    (own_rx_i || own_tx_i) [*5];
  endsequence
  a_loss_set: assert property (s_quiet |-> loss_o)
    else $error("loss not flagged");
  a_loss_clear: assert property (s_talk |-> !loss_o)
    else $error("loss flagged in exchange");
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == '0)
    else $error("read data outside slot");
  a_read_unmapped: assert property (rd_i && addr_i > R_CMD |=> rdata_o == '0)
    else $error("unmapped read not zero");
  a_lock_stopped: assert property (locked_o |-> !motor_run_o)
    else $error("running while locked");
  a_lock_holds: assert property (locked_o && !unlock |=> locked_o)
    else $error("lockout left alone");
  a_lock_cause: assert property ($rose(locked_o) |-> $fell(motor_run_o)
    && $past(lk_reg))
    else $error("lockout without trip");
  a_lock_entry: assert property ($fell(motor_run_o) && $past(lk_reg)
    |-> locked_o)
    else $error("trip did not lock");
  a_stop_cause: assert property ($fell(motor_run_o)
    |-> $past(loss_o) && $past(sw_reg))
    else $error("stop without enabled loss");
endmodule

bind tls_supervisor tls_supervisor_sva u_sva (
  .ref_clk_i   (ref_clk_i),
  .arst_n_i    (arst_n_i),
  .addr_i      (addr_i),
  .wdata_i     (wdata_i),
  .wr_i        (wr_i),
  .rd_i        (rd_i),
  .rdata_o     (rdata_o),
  .own_rx_i    (own_rx_i),
  .own_tx_i    (own_tx_i),
  .motor_run_o (motor_run_o),
  .loss_o      (loss_o),
  .locked_o    (locked_o)
);

// ==== verif/tls_host_model.sv ====
// Host model: polls this unit and chatters on the link
`timescale 1ns/1ps
module tls_host_model #(
  parameter int PERIOD = 15
) (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic arst_n_i,
  // Behaviour select
  input  wire logic poll_en_i,
  input  wire logic chat_en_i,
  // Link pins, low when idle
  output logic      own_rx_o,
  output logic      own_tx_o,
  output logic      any_rx_o
);
  logic [7:0] cnt_reg;
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
    if (!arst_n_i)
      cnt_reg <= 8'h00;
    else if (cnt_reg >= 8'(PERIOD))
      cnt_reg <= 8'h00;
    else
      cnt_reg <= cnt_reg + 8'h01;
  // Poll cycle kept well inside the shutdown delay
  assign own_rx_o = poll_en_i && cnt_reg < 8'h04;
  assign own_tx_o = poll_en_i && cnt_reg >= 8'h04 && cnt_reg < 8'h08;
  assign any_rx_o = own_rx_o || (chat_en_i && cnt_reg[2]);
endmodule

// ==== verif/tls_supervisor_tb.sv ====
// Testbench: supervisor against a polling host model
`timescale 1ns/1ps
module tls_supervisor_tb;
  import tls_pkg::*;
  logic              clk = 1'b0;
  logic              rst_n, wr, rd, start, poll, chat;
  logic              orx, otx, arx, run, loss, lock, irq;
  logic [MAP_W-1:0]  addr;
  logic [DATA_W-1:0] wdata, rdata, v;
  logic [7:0]        gstarts;
  logic [15:0]       gdelay;
  logic [31:0]       seed;
  int                n, err_count, n_checks;

  always #12.5 clk = ~clk;

  tls_supervisor #(.SEC_CYC(10)) u_dut (
    .ref_clk_i       (clk),
    .arst_n_i        (rst_n),
    .addr_i          (addr),
    .wdata_i         (wdata),
    .wr_i            (wr),
    .rd_i            (rd),
    .rdata_o         (rdata),
    .own_rx_i        (orx),
    .own_tx_i        (otx),
    .any_rx_i        (arx),
    .glb_starts_i    (gstarts),
    .glb_delay_min_i (gdelay),
    .start_req_i     (start),
    .motor_run_o     (run),
    .loss_o          (loss),
    .locked_o        (lock),
    .irq_o           (irq)
  );
  tls_host_model u_host (
    .ref_clk_i (clk),
    .arst_n_i  (rst_n),
    .poll_en_i (poll),
    .chat_en_i (chat),
    .own_rx_o  (orx),
    .own_tx_o  (otx),
    .any_rx_o  (arx)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [31:0] rw(input logic [7:0] c,
                                     input logic [15:0] m);
    return {8'h00, m, c};
  endfunction

  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus_wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rc(input string nm, input logic [5:0] a,
                    input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
    chk(nm, v, e);
  endtask
  // Bounded wait for the motor level, then compare it
  task automatic wait_run(input logic lvl, input int max);
    n = 0;
    while (run !== lvl && n < max)
    begin
      @(posedge clk);
      n++;
    end
    chk("run", 32'(run), 32'(lvl));
  endtask
  task automatic results;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    {rst_n, wr, rd, start, poll, chat} = 6'h00;
    addr = '0;
    wdata = '0;
    gstarts = 8'h00;
    gdelay = 16'h0001;
    seed = 32'hC608;
    err_count = 0;
    n_checks = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rc("ctrl", R_CTRL, 32'h0);
    rc("bypass", R_BYPASS, {16'h0, RST_BYPASS_SEC});
    rc("shdn", R_SHDN, {16'h0, RST_SHDN_SEC});
    rc("hold", R_HOLD, {16'h0, RST_HOLD_SEC});
    rc("restart", R_RESTART, rw(RST_STARTS, RST_DELAY_MIN));
    rc("almsw", R_ALMSW, {16'h0, RST_ALMSW});
    rc("unmapped", 6'h2C, 32'h0);
    rc("irq clr", R_IRQ_CLR, 32'h0);
    rc("status", R_STATUS, 32'h1);
    chk("status", v & 32'h7, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      seed = xs(seed);
      gdelay <= seed[31:16];
      bus_wr(R_ALMSW, {16'h0, seed[15:0]});
      rc("almsw", R_ALMSW, {16'h0, seed[15:0]});
    end
    bus_wr(R_BYPASS, 32'h4);
    bus_wr(R_SHDN, 32'h2);
    bus_wr(R_HOLD, 32'h2);
    bus_wr(R_CTRL, 32'h1 << CTRL_LOCKOUT_EN);
    bus_wr(R_ALMSW, 32'h1 << SW_COMM_LOSS);
    bus_wr(R_IRQ_EN, 32'h0);
    // No traffic yet, so a start under loss is refused
    start <= 1'b1;
    repeat (10) @(posedge clk);
    start <= 1'b0;
    chk("quiet start", 32'(run), 32'h0);
    chk("loss", 32'(loss), 32'h1);
    chat <= 1'b1;
    repeat (10) @(posedge clk);
    bus_wr(R_CMD, 32'h1 << CMD_MAN_START);
    chat <= 1'b0;
    wait_run(1'b1, 10);
    wait_run(1'b0, 100);
    chk("stop time", 32'(n >= 45 && n <= 75), 32'h1);
    chk("locked", 32'(lock), 32'h1);
    chk("irq masked", 32'(irq), 32'h0);
    bus_wr(R_IRQ_EN, 32'h1 << IRQ_TRIP);
    // Enable lands at the edge the task returns on
    #1;
    chk("irq", 32'(irq), 32'h1);
    rc("irq st", R_IRQ_ST, 32'h3);
    chk("irq st", v & 32'h3, 32'h3);
    chat <= 1'b1;
    start <= 1'b1;
    repeat (30) @(posedge clk);
    start <= 1'b0;
    chk("locked start", 32'(run), 32'h0);
    bus_wr(R_IRQ_CLR, 32'hF);
    #1;
    chk("irq clr", 32'(irq), 32'h0);
    bus_wr(R_CMD, 32'h1 << CMD_LOCK_CLR);
    #1;
    chk("unlock", 32'(lock), 32'h0);
    // Local policy: one restart after two minutes
    bus_wr(R_CTRL, 32'h1 << CTRL_LOCAL_RST);
    bus_wr(R_RESTART, rw(8'h01, 16'h0002));
    poll <= 1'b1;
    bus_wr(R_CMD, 32'h1 << CMD_MAN_START);
    wait_run(1'b1, 10);
    repeat (200) @(posedge clk);
    chk("polled", 32'(run), 32'h1);
    poll <= 1'b0;
    wait_run(1'b0, 100);
    chk("no lock", 32'(lock), 32'h0);
    wait_run(1'b1, 1300);
    chk("restart wait", 32'(n >= 590), 32'h1);
    wait_run(1'b0, 100);
    repeat (1500) @(posedge clk);
    chk("limit", 32'(run), 32'h0);
    // Global policy with no restarts allowed
    bus_wr(R_CTRL, 32'h0);
    // Still waiting after the limit; only the start pin is taken there
    start <= 1'b1;
    wait_run(1'b1, 10);
    start <= 1'b0;
    wait_run(1'b0, 100);
    repeat (1500) @(posedge clk);
    chk("global", 32'(run), 32'h0);
    results();
  end

  // Whole run is about 4400 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    results();
  end
endmodule
